// >>> uti_pkg.sv
// Operation
// - Acknowledge clears master enable; later requests only set their flags.
// - Firmware re-enabling master and source during service allows nested acknowledge.
// - Full call stack withholds every acknowledge until the stack pointer drops.
// - Acknowledge pushes only the program counter and branches to the vector.
// - Control register: master bit 0, USB enable bit 1, timer enable bit 3.
// - Control register: USB flag bit 4, timer flag bit 6, 1 means pending.
// - USB flag sets on FIFO access, suspend, resume or bus reset.
// - Enabled USB request calls vector 04H, clearing USB flag and master enable.
// - FIFO access sets its endpoint request bit; firmware clears it afterwards.
// - Bus suspend sets status/control bit 0 and raises the USB interrupt.
// - Bus resume sets status/control bit 3 and raises the USB interrupt.
// - Bus reset sets the bus-reset flag and raises USB interrupt; firmware clears.
// - Timer overflow sets timer flag; enabled request calls 0CH, clearing flag, master.
// - Interrupt return sets master enable; plain subroutine return leaves it alone.
// - During service acknowledges wait for return or re-enable with stack room.
// - Requests are sampled once per instruction cycle on the phase-two tick.
// - Simultaneous requests: USB first, timer second.
// - Request flags stay set until serviced or cleared by software.
// - Both sources can wake the device from halt.
// - A source whose flag was already set at halt entry cannot wake it.
// - Wake with source disabled or stack full continues at next instruction.
package uti_pkg;

    // Register indices; byte address is four times the index
    localparam logic [7:0] UTI_IDX_IRQ_CONTROL   = 8'h0b;
    localparam logic [7:0] UTI_IDX_USB_STATUS    = 8'h1a;
    localparam logic [7:0] UTI_IDX_USB_PIPE_REQ  = 8'h1b;
    localparam logic [9:0] UTI_ADDR_IRQ_CONTROL  = {UTI_IDX_IRQ_CONTROL, 2'b00};
    localparam logic [9:0] UTI_ADDR_USB_STATUS   = {UTI_IDX_USB_STATUS, 2'b00};
    localparam logic [9:0] UTI_ADDR_USB_PIPE_REQ = {UTI_IDX_USB_PIPE_REQ, 2'b00};

    // Interrupt control register fields
    localparam int UTI_BIT_MASTER_EN = 0;
    localparam int UTI_BIT_USB_EN    = 1;
    localparam int UTI_BIT_TIMER_EN  = 3;
    localparam int UTI_BIT_USB_FLAG  = 4;
    localparam int UTI_BIT_TIMER_FLAG = 6;

    // USB status/control register fields
    localparam int UTI_BIT_SUSPEND   = 0;
    localparam int UTI_BIT_BUS_RESET = 1;
    localparam int UTI_BIT_RESUME    = 3;

    localparam logic [7:0] UTI_RESET_IRQ_CONTROL = 8'h00;
    localparam logic [7:0] UTI_RESET_USB_STATUS  = 8'h00;

    // Vectors
    localparam logic [7:0] UTI_VECTOR_USB   = 8'h04;
    localparam logic [7:0] UTI_VECTOR_TIMER = 8'h0c;

    // Instruction cycle timing
    localparam logic [1:0] UTI_TICK_PHASE = 2'h1;

    localparam logic [1:0] UTI_HTRANS_NONSEQ = 2'b10;

endpackage : uti_pkg

// >>> uti_irq_ctrl.sv
module uti_irq_ctrl
    import uti_pkg::*;
#(
    parameter int NUM_EP = 2
)(
    input  wire logic              clock,
    input  wire logic              resetn,
    // AHB-Lite slave
    input  wire logic              hsel,
    input  wire logic [31:0]       haddr,
    input  wire logic [1:0]        htrans,
    input  wire logic              hwrite,
    input  wire logic [2:0]        hsize,
    input  wire logic [31:0]       hwdata,
    input  wire logic              hready,
    output logic                   hreadyout,
    output logic [31:0]            hrdata,
    output logic                   hresp,
    // USB and timer events, one-cycle pulses
    input  wire logic [NUM_EP-1:0] fifo_access,
    input  wire logic              usb_suspend,
    input  wire logic              usb_resume,
    input  wire logic              usb_bus_reset,
    input  wire logic              timer_overflow,
    // Core sequencer and stack
    input  wire logic              stack_full,
    input  wire logic              irq_exit_enable_instr,
    input  wire logic              halt_enter,
    output logic                   irq_call,
    output logic [7:0]             irq_vector,
    output logic                   halted,
    output logic                   halt_wake,
    output logic                   wake_to_next,
    output logic                   phase_two_tick
);

    logic [1:0]        phase;
    logic              master_irq_enable;
    logic              usb_irq_enable;
    logic              timer_irq_enable;
    logic              usb_irq_flag;
    logic              timer_irq_flag;
    logic              bus_suspend;
    logic              bus_resume;
    logic              usb_bus_reset_flag;
    logic [NUM_EP-1:0] usb_pipe_request_reg;
    logic              wake_mask_usb;
    logic              wake_mask_timer;
    logic              wr_active;
    logic [9:0]        wr_addr;

    // Bus decode
    wire       addr_phase   = hsel & hready & (htrans == UTI_HTRANS_NONSEQ);
    wire       rd_req       = addr_phase & ~hwrite;
    wire [9:0] rd_addr      = haddr[9:0];
    wire       wr_control   = wr_active & (wr_addr == UTI_ADDR_IRQ_CONTROL);
    wire       wr_status    = wr_active & (wr_addr == UTI_ADDR_USB_STATUS);
    wire       wr_pipe      = wr_active & (wr_addr == UTI_ADDR_USB_PIPE_REQ);

    // Instruction phase tick
    wire       tick         = (phase == UTI_TICK_PHASE);

    // Events
    wire       fifo_any     = |fifo_access;
    wire       usb_event    = fifo_any | usb_suspend | usb_resume | usb_bus_reset;

    // Acknowledge arbitration
    wire       usb_pending  = usb_irq_enable & usb_irq_flag;
    wire       timer_pending = timer_irq_enable & timer_irq_flag;
    wire       ack_allowed  = tick & master_irq_enable & ~stack_full & ~halted;
    wire       ack_usb      = ack_allowed & usb_pending;
    wire       ack_timer    = ack_allowed & ~usb_pending & timer_pending;
    wire       ack_any      = ack_usb | ack_timer;
    wire [7:0] ack_vector   = ack_usb ? UTI_VECTOR_USB : UTI_VECTOR_TIMER;

    // Next values of the control register
    wire       sw_master    = wr_control ? hwdata[UTI_BIT_MASTER_EN] : master_irq_enable;
    wire       sw_usb_en    = wr_control ? hwdata[UTI_BIT_USB_EN] : usb_irq_enable;
    wire       sw_timer_en  = wr_control ? hwdata[UTI_BIT_TIMER_EN] : timer_irq_enable;
    wire       sw_usb_flag  = wr_control ? hwdata[UTI_BIT_USB_FLAG] : usb_irq_flag;
    wire       sw_timer_flag = wr_control ? hwdata[UTI_BIT_TIMER_FLAG] : timer_irq_flag;
    // Return-from-interrupt sets master; acknowledge clears it last
    wire       next_master  = ~ack_any & (irq_exit_enable_instr | sw_master);
    // Flags hold until serviced or written; a new event wins over any clear
    wire       next_usb_flag   = usb_event | (sw_usb_flag & ~ack_usb);
    wire       next_timer_flag = timer_overflow | (sw_timer_flag & ~ack_timer);

    // Next values of the USB status/control register, set wins over write
    wire       next_suspend = usb_suspend | (wr_status ? hwdata[UTI_BIT_SUSPEND] : bus_suspend);
    wire       next_resume  = usb_resume | (wr_status ? hwdata[UTI_BIT_RESUME] : bus_resume);
    wire       next_bus_reset_flag = usb_bus_reset
                                   | (wr_status ? hwdata[UTI_BIT_BUS_RESET] : usb_bus_reset_flag);
    // Each endpoint bit is set by its own FIFO access and cleared by firmware
    wire [NUM_EP-1:0] next_pipe;
    for (genvar ep = 0; ep < NUM_EP; ep++)
    begin : g_pipe
        assign next_pipe[ep] = fifo_access[ep]
                             | (wr_pipe ? hwdata[ep] : usb_pipe_request_reg[ep]);
    end : g_pipe

    // Read images, built from next values so a write just before a read is seen
    wire [7:0] control_image;
    assign control_image[UTI_BIT_MASTER_EN]  = next_master;
    assign control_image[UTI_BIT_USB_EN]     = sw_usb_en;
    assign control_image[2]                  = 1'b0;
    assign control_image[UTI_BIT_TIMER_EN]   = sw_timer_en;
    assign control_image[UTI_BIT_USB_FLAG]   = next_usb_flag;
    assign control_image[5]                  = 1'b0;
    assign control_image[UTI_BIT_TIMER_FLAG] = next_timer_flag;
    assign control_image[7]                  = 1'b0;

    wire [7:0] status_image;
    assign status_image[UTI_BIT_SUSPEND]   = next_suspend;
    assign status_image[UTI_BIT_BUS_RESET] = next_bus_reset_flag;
    assign status_image[2]                 = 1'b0;
    assign status_image[UTI_BIT_RESUME]    = next_resume;
    assign status_image[7:4]               = 4'h0;

    wire [31:0] pipe_image = {{(32-NUM_EP){1'b0}}, next_pipe};

    wire        rd_control = (rd_addr == UTI_ADDR_IRQ_CONTROL);
    wire        rd_status  = (rd_addr == UTI_ADDR_USB_STATUS);
    wire        rd_pipe    = (rd_addr == UTI_ADDR_USB_PIPE_REQ);
    wire [31:0] rd_value   = rd_control ? {24'h00_0000, control_image}
                           : rd_status  ? {24'h00_0000, status_image}
                           : rd_pipe    ? pipe_image
                           : 32'h0000_0000;
    wire [31:0] next_hrdata = rd_req ? rd_value : 32'h0000_0000;

    // Halt and wake
    wire usb_wake       = halted & usb_event & wake_mask_usb;
    wire timer_wake     = halted & timer_overflow & wake_mask_timer;
    wire wake           = usb_wake | timer_wake;
    wire wake_vectored  = master_irq_enable & ~stack_full
                        & ((usb_wake & usb_irq_enable) | (timer_wake & timer_irq_enable));
    wire next_halted    = halt_enter | (halted & ~wake);

    always_ff @(posedge clock or negedge resetn)
    begin
        if (!resetn)
        begin
            phase <= 2'h0;
        end
        else
        begin
            phase <= phase + 2'h1;
        end
    end

    // Bus side: zero wait states, every response OKAY
    always_ff @(posedge clock or negedge resetn)
    begin
        if (!resetn)
        begin
            wr_active <= 1'b0;
        end
        else
        begin
            wr_active <= addr_phase & hwrite;
        end
    end

    always_ff @(posedge clock or negedge resetn)
    begin
        if (!resetn)
        begin
            wr_addr <= 10'h000;
        end
        else
        begin
            wr_addr <= haddr[9:0];
        end
    end

    always_ff @(posedge clock or negedge resetn)
    begin
        if (!resetn)
        begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end
        else
        begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end
    end

    always_ff @(posedge clock or negedge resetn)
    begin
        if (!resetn)
        begin
            hrdata <= 32'h0000_0000;
        end
        else
        begin
            hrdata <= next_hrdata;
        end
    end

    // Interrupt control register, one process per field
    always_ff @(posedge clock or negedge resetn)
    begin
        if (!resetn)
        begin
            master_irq_enable <= UTI_RESET_IRQ_CONTROL[UTI_BIT_MASTER_EN];
        end
        else
        begin
            master_irq_enable <= next_master;
        end
    end

    always_ff @(posedge clock or negedge resetn)
    begin
        if (!resetn)
        begin
            usb_irq_enable <= UTI_RESET_IRQ_CONTROL[UTI_BIT_USB_EN];
        end
        else
        begin
            usb_irq_enable <= sw_usb_en;
        end
    end

    always_ff @(posedge clock or negedge resetn)
    begin
        if (!resetn)
        begin
            timer_irq_enable <= UTI_RESET_IRQ_CONTROL[UTI_BIT_TIMER_EN];
        end
        else
        begin
            timer_irq_enable <= sw_timer_en;
        end
    end

    always_ff @(posedge clock or negedge resetn)
    begin
        if (!resetn)
        begin
            usb_irq_flag <= UTI_RESET_IRQ_CONTROL[UTI_BIT_USB_FLAG];
        end
        else
        begin
            usb_irq_flag <= next_usb_flag;
        end
    end

    always_ff @(posedge clock or negedge resetn)
    begin
        if (!resetn)
        begin
            timer_irq_flag <= UTI_RESET_IRQ_CONTROL[UTI_BIT_TIMER_FLAG];
        end
        else
        begin
            timer_irq_flag <= next_timer_flag;
        end
    end

    // USB status/control and pipe request registers
    always_ff @(posedge clock or negedge resetn)
    begin
        if (!resetn)
        begin
            bus_suspend <= UTI_RESET_USB_STATUS[UTI_BIT_SUSPEND];
        end
        else
        begin
            bus_suspend <= next_suspend;
        end
    end

    always_ff @(posedge clock or negedge resetn)
    begin
        if (!resetn)
        begin
            bus_resume <= UTI_RESET_USB_STATUS[UTI_BIT_RESUME];
        end
        else
        begin
            bus_resume <= next_resume;
        end
    end

    always_ff @(posedge clock or negedge resetn)
    begin
        if (!resetn)
        begin
            usb_bus_reset_flag <= UTI_RESET_USB_STATUS[UTI_BIT_BUS_RESET];
        end
        else
        begin
            usb_bus_reset_flag <= next_bus_reset_flag;
        end
    end

    always_ff @(posedge clock or negedge resetn)
    begin
        if (!resetn)
        begin
            usb_pipe_request_reg <= '0;
        end
        else
        begin
            usb_pipe_request_reg <= next_pipe;
        end
    end

    // Acknowledge pushes the program counter only and branches to the vector
    always_ff @(posedge clock or negedge resetn)
    begin
        if (!resetn)
        begin
            irq_call <= 1'b0;
        end
        else
        begin
            irq_call <= ack_any;
        end
    end

    always_ff @(posedge clock or negedge resetn)
    begin
        if (!resetn)
        begin
            irq_vector <= 8'h00;
        end
        else
        begin
            irq_vector <= ack_any ? ack_vector : irq_vector;
        end
    end

    always_ff @(posedge clock or negedge resetn)
    begin
        if (!resetn)
        begin
            phase_two_tick <= 1'b0;
        end
        else
        begin
            phase_two_tick <= tick;
        end
    end

    // Halt and wake
    always_ff @(posedge clock or negedge resetn)
    begin
        if (!resetn)
        begin
            halted <= 1'b0;
        end
        else
        begin
            halted <= next_halted;
        end
    end

    always_ff @(posedge clock or negedge resetn)
    begin
        if (!resetn)
        begin
            halt_wake    <= 1'b0;
            wake_to_next <= 1'b0;
        end
        else
        begin
            halt_wake    <= wake;
            wake_to_next <= wake & ~wake_vectored;
        end
    end

    // A flag already pending at halt entry disarms that source's wake
    always_ff @(posedge clock or negedge resetn)
    begin
        if (!resetn)
        begin
            wake_mask_usb   <= 1'b0;
            wake_mask_timer <= 1'b0;
        end
        else if (halt_enter)
        begin
            wake_mask_usb   <= ~usb_irq_flag;
            wake_mask_timer <= ~timer_irq_flag;
        end
    end

endmodule : uti_irq_ctrl

// >>> uti_irq_ctrl_asserts.sv
module uti_irq_ctrl_asserts
    import uti_pkg::*;
(
    input wire logic       clock,
    input wire logic       resetn,
    input wire logic       stack_full,
    input wire logic       irq_call,
    input wire logic [7:0] irq_vector,
    input wire logic       halted,
    input wire logic       halt_wake,
    input wire logic       wake_to_next,
    input wire logic       phase_two_tick
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clock); endclocking
    default disable iff (!resetn);
    property p_call_tick; irq_call |-> phase_two_tick; endproperty
    a_call_tick: assert property (p_call_tick) else $error("call off tick");
    property p_tick; phase_two_tick |=> !phase_two_tick [*3] ##1 phase_two_tick; endproperty
    a_tick: assert property (p_tick) else $error("tick period wrong");
    property p_vec; irq_call |-> irq_vector == UTI_VECTOR_USB || irq_vector == UTI_VECTOR_TIMER; endproperty
    a_vec: assert property (p_vec) else $error("bad vector");
    property p_stack; irq_call |-> !$past(stack_full); endproperty
    a_stack: assert property (p_stack) else $error("call with full stack");
    property p_halt; irq_call |-> !$past(halted); endproperty
    a_halt: assert property (p_halt) else $error("call while halted");
    property p_next; wake_to_next |-> halt_wake; endproperty
    a_next: assert property (p_next) else $error("next without wake");
    property p_wake; halt_wake |-> !halted; endproperty
    a_wake: assert property (p_wake) else $error("wake left halted");
    property p_vhold; $changed(irq_vector) |-> irq_call; endproperty
    a_vhold: assert property (p_vhold) else $error("vector moved alone");
endmodule : uti_irq_ctrl_asserts

bind uti_irq_ctrl uti_irq_ctrl_asserts uti_irq_ctrl_asserts_i (.clock, .resetn, .stack_full, .irq_call,
    .irq_vector, .halted, .halt_wake, .wake_to_next, .phase_two_tick);

// >>> uti_core_model.sv
module uti_core_model #(
    parameter int DEPTH = 2
)(
    input  wire logic clock,
    input  wire logic resetn,
    input  wire logic irq_call,
    input  wire logic irq_exit_enable_instr,
    output logic      stack_full
);
    timeunit 1ns;
    timeprecision 1ps;
    int sp;
    // Only the return address goes on the stack
    always_ff @(posedge clock or negedge resetn)
    begin
        if (!resetn)
        begin
            sp <= 0;
        end
        else
        begin
            sp <= sp + int'(irq_call) - int'(irq_exit_enable_instr);
        end
    end
    assign stack_full = (sp >= DEPTH);
endmodule : uti_core_model

// >>> tb.sv
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin err_count++; \
    $display("[FAIL] %0t got %h exp %h", $time, (a), (b)); end end
module tb
    import uti_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int M = 1 << UTI_BIT_MASTER_EN;
    localparam int U = 1 << UTI_BIT_USB_EN;
    localparam int T = 1 << UTI_BIT_TIMER_EN;
    localparam int UF = 1 << UTI_BIT_USB_FLAG;
    localparam int TF = 1 << UTI_BIT_TIMER_FLAG;
    localparam logic [9:0] CT = UTI_ADDR_IRQ_CONTROL;
    localparam logic [9:0] ST = UTI_ADDR_USB_STATUS;
    localparam logic [9:0] PR = UTI_ADDR_USB_PIPE_REQ;
    logic        clock, resetn, hsel, hwrite, stack_full, irq_call, halted, halt_wake, wake_to_next, tick;
    logic        hreadyout, hresp;
    logic [1:0]  htrans;
    logic [7:0]  ev, irq_vector;
    logic [31:0] haddr, hwdata, hrdata, rd, rnd;
    int          err_count, check_count, seed, k;
    int          sb[5] = '{0, 1, UTI_BIT_SUSPEND, UTI_BIT_RESUME, UTI_BIT_BUS_RESET};
    uti_irq_ctrl uti_irq_ctrl_i (.clock, .resetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
        .hready(hreadyout), .hreadyout, .hrdata, .hresp, .fifo_access(ev[1:0]), .usb_suspend(ev[2]),
        .usb_resume(ev[3]), .usb_bus_reset(ev[4]), .timer_overflow(ev[5]), .stack_full,
        .irq_exit_enable_instr(ev[7]), .halt_enter(ev[6]), .irq_call, .irq_vector, .halted, .halt_wake,
        .wake_to_next, .phase_two_tick(tick));
    uti_core_model uti_core_model_i (.clock, .resetn, .irq_call, .irq_exit_enable_instr(ev[7]), .stack_full);
    initial
    begin
        clock = 1'b0;
        forever #2 clock = ~clock;
    end
    task automatic finish_test;
        $display("checks %0d mismatches %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : finish_test
    // Bounded wait: 0 ready, 1 call, 2 wake
    task automatic wt(input int s);
        logic v;
        for (int n = 0; n < 20; n++)
        begin
            @(negedge clock);
            v = (s == 0) ? hreadyout : (s == 1) ? irq_call : halt_wake;
            if (v === 1'b1)
                break;
        end
        `CHK(v, 1'b1)
        if (v !== 1'b1)
            finish_test;
    endtask : wt
    task automatic idle(input int n, input int s);
        repeat (n)
        begin
            @(negedge clock);
            `CHK((s == 1) ? irq_call : halt_wake, 1'b0)
        end
    endtask : idle
    task automatic bus(input logic w, input logic [9:0] a, input logic [31:0] d);
        @(posedge clock);
        hsel <= 1'b1;
        htrans <= UTI_HTRANS_NONSEQ;
        hwrite <= w;
        haddr <= {22'h0, a};
        wt(0);
        @(posedge clock);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        wt(0);
        rd = hrdata;
        `CHK(hresp, 1'b0)
    endtask : bus
    task automatic rchk(input logic [9:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        `CHK(rd, e)
    endtask : rchk
    task automatic pls(input logic [7:0] m);
        @(posedge clock);
        ev <= m;
        @(posedge clock);
        ev <= 8'h00;
    endtask : pls
    task automatic wcall(input logic [7:0] v);
        wt(1);
        `CHK(irq_vector, v)
    endtask : wcall
    initial
    begin
        {hsel, hwrite, htrans, haddr, hwdata, ev} = '0;
        resetn = 1'b0;
        seed = 89024;
        repeat (8) @(posedge clock);
        resetn <= 1'b1;
        rchk(CT, 32'h0);
        rnd = $random(seed);
        bus(1'b1, 10'h3fc, rnd);
        rchk(10'h3fc, 32'h0);
        bus(1'b1, CT, {rnd[31:8], 8'hfe});
        rchk(CT, U | T | UF | TF);
        bus(1'b1, CT, rnd & 32'hffff_ff00);
        rchk(CT, 32'h0);
        bus(1'b1, PR, rnd);
        rchk(PR, rnd & 32'h3);
        bus(1'b1, PR, 32'h0);
        $display("test registers done");
        for (k = 0; k < 5; k++)
        begin
            pls(8'h01 << k);
            rchk(CT, UF);
            rchk((k < 2) ? PR : ST, 1 << sb[k]);
            bus(1'b1, CT, M | U | UF);
            wcall(UTI_VECTOR_USB);
            rchk(CT, U);
            bus(1'b1, (k < 2) ? PR : ST, 32'h0);
            pls(8'h80);
            rchk(CT, M | U);
            bus(1'b1, CT, 32'h0);
        end
        $display("test usb events done");
        bus(1'b1, CT, M | U | T);
        pls(8'h24);
        wcall(UTI_VECTOR_USB);
        rchk(CT, U | T | TF);
        idle(12, 1);
        bus(1'b1, CT, M | U | T | TF);
        wcall(UTI_VECTOR_TIMER);
        pls(8'h08);
        bus(1'b1, CT, M | U | T | UF);
        idle(12, 1);
        pls(8'h80);
        wcall(UTI_VECTOR_USB);
        pls(8'h80);
        pls(8'h80);
        bus(1'b1, CT, 32'h0);
        bus(1'b1, ST, 32'h0);
        $display("test nesting done");
        pls(8'h40);
        @(negedge clock);
        `CHK(halted, 1'b1)
        pls(8'h20);
        wt(2);
        `CHK(wake_to_next, 1'b1)
        pls(8'h40);
        pls(8'h20);
        idle(8, 2);
        `CHK(halted, 1'b1)
        bus(1'b1, CT, M | U | T | TF);
        pls(8'h04);
        wt(2);
        `CHK(wake_to_next, 1'b0)
        wcall(UTI_VECTOR_USB);
        $display("test halt done");
        finish_test;
    end
endmodule : tb
